// ==== apc_consts.vh ====
// Constants of the audio path configuration block: frame layout,
// load opcodes, field positions and reset values.
// Assumes inclusion by bare name from the design and bench files.
`ifndef APC_CONSTS_VH
`define APC_CONSTS_VH

// Serial frame: one opcode byte then one 16-bit data word, MSB first
`define APC_FRAME_BITS        5'd24
`define APC_OP_MSB            23
`define APC_OP_LSB            16
`define APC_OP_LOAD_LOW       8'hB8
`define APC_OP_LOAD_HIGH      8'hB9

// Buffered (low) register fields
`define APC_VOL_PD_BIT        0
`define APC_SPK_MSB           2
`define APC_SPK_LSB           1
`define APC_OUT_SRC_MSB       4
`define APC_OUT_SRC_LSB       3
`define APC_AOUT_PD_BIT       5
`define APC_AOUT_SRC_MSB      8
`define APC_AOUT_SRC_LSB      6
`define APC_IN_SRC_BIT        9
`define APC_AUX_PD_BIT        10
`define APC_AUX_GAIN_MSB      12
`define APC_AUX_GAIN_LSB      11
`define APC_AIN_PD_BIT        13
`define APC_AIN_GAIN_MSB      15
`define APC_AIN_GAIN_LSB      14

// Commit (high) register fields
`define APC_AGC_PD_BIT        0
`define APC_FILT_PD_BIT       1
`define APC_RATE_MSB          3
`define APC_RATE_LSB          2
`define APC_FILT_SRC_BIT      4
`define APC_MIX2_MSB          6
`define APC_MIX2_LSB          5
`define APC_MIX1_MSB          8
`define APC_MIX1_LSB          7
`define APC_MIX1_SRC_MSB      10
`define APC_MIX1_SRC_LSB      9
`define APC_ATTEN_MSB         13
`define APC_ATTEN_LSB         11
`define APC_VOL_SRC_MSB       15
`define APC_VOL_SRC_LSB       14

// Field codes
`define APC_SPK_HIGH_GAIN     2'h1
`define APC_MIX_OFF           2'h3
`define APC_AOUT_PASS_THRU    3'h0

// Reset values: every stage powered down except the auxiliary output
`define APC_LOW_RESET         16'h2421
`define APC_HIGH_RESET        16'h01E3

`endif

// ==== apc_pin_sync.v ====
// Three-stage input synchroniser with agreement filter, one per bit.
// Assumes sys_clk domain; inputs may change at any time.
`default_nettype none
module apc_pin_sync #(
	parameter WIDTH = 3,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	// Clock and reset
	input  wire             sys_clk,
	input  wire             rst_n,
	// Raw pins and filtered levels
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] level
);

	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;

	// Level only moves when stages two and three agree
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : gen_bit
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					stage1[g] <= INIT[g];
					stage2[g] <= INIT[g];
					stage3[g] <= INIT[g];
					level[g]  <= INIT[g];
				end else begin
					stage1[g] <= pin_in[g];
					stage2[g] <= stage1[g];
					stage3[g] <= stage2[g];
					if (stage2[g] == stage3[g])
						level[g] <= stage3[g];
				end
			end
		end
	endgenerate

endmodule // apc_pin_sync
`default_nettype wire

// ==== apc_config_regs.v ====
// Audio path configuration registers loaded over a serial slave port.
// Assumes a host master drives ss_n, sclk and mosi, sampled on sys_clk.
//
// Summary of operation
// - Low register bits 8..6 pick analog output source; zero means pass-through.
// - Low register bit 5 powers analog output amplifier down when one.
// - Low register bits 15..14 set analog input gain; code 01 is 9dB attenuation.
// - Low register bit 13 powers analog input amplifier down when one.
// - Low register bits 4..3 pick output source; 01 analog in, 00 volume.
// - Low register bits 2..1 drive speaker; 01 speaker high gain, aux off.
// - Low register bit 0 powers volume attenuator down when one.
// - Low register bit 10 powers auxiliary input amplifier down when one.
// - Either mixer mode field at 11 powers that mixer down.
// - High register bit 1 powers low-pass filter down when one.
// - High register bit 0 powers gain control amplifier down when one.
// - Low register bit 9 picks input source; zero selects gain control output.
// - Low register bits 12..11 hold auxiliary input gain.
// - High register bits 3..2 pick sample rate; 01 6.4 kHz, 10 5.3 kHz.
// - High register bit 4 picks filter source; zero selects first mixer.
// - High register bits 10..9 pick first mixer source; 00 analog input.
// - First mixer mode 01 takes its mux only, 10 input source only.
// - Second mixer mode 10 takes low-pass filter output only.
// - High bits 13..11 set attenuation, bits 15..14 pick volume source.
// - Both registers take effect together when select rises after a high load.
// - A low-register load waits in a buffer until the next high load.
// - Loads are accepted powered down but appear only with power-up set.
`default_nettype none
`include "apc_consts.vh"
module apc_config_regs (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_n,
	// Serial slave pins
	input  wire        ss_n,
	input  wire        sclk,
	input  wire        mosi,
	// Power-up bit of the control word
	input  wire        power_up_bit,
	// Analog output and input stages
	output reg  [2:0]  analog_out_source_select,
	output reg         analog_out_power_down,
	output reg         pass_through_path,
	output reg  [1:0]  analog_in_gain,
	output reg         analog_in_power_down,
	output reg  [1:0]  output_source_select,
	output reg  [1:0]  speaker_driver_control,
	output reg         speaker_high_gain,
	output reg         aux_out_power_down,
	output reg         volume_power_down,
	output reg         aux_in_power_down,
	output reg  [1:0]  aux_in_gain,
	output reg         input_source_select,
	// Mixers, filter and volume
	output reg  [1:0]  first_mixer_mode,
	output reg         first_mixer_power_down,
	output reg  [1:0]  second_mixer_mode,
	output reg         second_mixer_power_down,
	output reg  [1:0]  first_mixer_source_select,
	output reg         filter_power_down,
	output reg         gain_control_power_down,
	output reg  [1:0]  sample_rate_select,
	output reg         filter_source_select,
	output reg  [2:0]  attenuation_level,
	output reg  [1:0]  volume_source_select,
	// Status
	output reg         config_applied
);

	// Filtered pin levels
	wire        ss_n_lvl;
	wire        sclk_lvl;
	wire        mosi_lvl;
	reg         ss_n_prev;
	reg         sclk_prev;

	// Frame capture
	reg  [23:0] shift;
	reg  [4:0]  bit_count;

	reg  [15:0] path_config_low_buffered;
	reg  [15:0] path_config_high_commit;
	reg  [15:0] active_low;
	// Commit register is itself the live high setting
	wire [15:0] active_high = path_config_high_commit;
	reg         pending_apply;

	wire        sclk_rise = sclk_prev == 1'b0 && sclk_lvl == 1'b1;
	wire        frame_end = ss_n_prev == 1'b0 && ss_n_lvl == 1'b1;
	wire        frame_ok  = bit_count == `APC_FRAME_BITS;
	wire [7:0]  opcode    = shift[`APC_OP_MSB:`APC_OP_LSB];
	wire [15:0] data_word = shift[15:0];

	// Pins pass three stages; select idles high
	apc_pin_sync #(
		.WIDTH (3),
		.INIT  (3'h4)
	) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.pin_in  ({ss_n, sclk, mosi}),
		.level   ({ss_n_lvl, sclk_lvl, mosi_lvl})
	);

	// Edge history of filtered levels
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ss_n_prev <= 1'b1;
			sclk_prev <= 1'b0;
		end else begin
			ss_n_prev <= ss_n_lvl;
			sclk_prev <= sclk_lvl;
		end
	end

	// Shift in MSB first; count saturates so long frames are refused
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift     <= 24'h000000;
			bit_count <= 5'h00;
		end else if (ss_n_lvl) begin
			bit_count <= 5'h00;
		end else if (sclk_rise) begin
			shift <= {shift[22:0], mosi_lvl};
			if (bit_count != 5'h1F)
				bit_count <= bit_count + 5'h01;
		end
	end

	// Register loads at the select rising edge
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			path_config_low_buffered <= `APC_LOW_RESET;
			path_config_high_commit  <= `APC_HIGH_RESET;
			active_low               <= `APC_LOW_RESET;
		end else if (frame_end && frame_ok) begin
			if (opcode == `APC_OP_LOAD_LOW)
				path_config_low_buffered <= data_word;
			if (opcode == `APC_OP_LOAD_HIGH) begin
				path_config_high_commit <= data_word;
				active_low              <= path_config_low_buffered;
			end
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_apply <= 1'b1;
		end else if (frame_end && frame_ok && opcode == `APC_OP_LOAD_HIGH) begin
			pending_apply <= 1'b1;
		end else if (power_up_bit) begin
			pending_apply <= 1'b0;
		end
	end

	// Visible settings refresh only while powered up with a commit pending
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Decoded flags agree with the reset fields from the first cycle
			analog_out_source_select  <= 3'h0;
			analog_out_power_down     <= 1'b1;
			pass_through_path         <= 1'b1;
			analog_in_gain            <= 2'h0;
			analog_in_power_down      <= 1'b1;
			output_source_select      <= 2'h0;
			speaker_driver_control    <= 2'h0;
			speaker_high_gain         <= 1'b0;
			aux_out_power_down        <= 1'b0;
			volume_power_down         <= 1'b1;
			aux_in_power_down         <= 1'b1;
			aux_in_gain               <= 2'h0;
			input_source_select       <= 1'b0;
			first_mixer_mode          <= `APC_MIX_OFF;
			first_mixer_power_down    <= 1'b1;
			second_mixer_mode         <= `APC_MIX_OFF;
			second_mixer_power_down   <= 1'b1;
			first_mixer_source_select <= 2'h0;
			filter_power_down         <= 1'b1;
			gain_control_power_down   <= 1'b1;
			sample_rate_select        <= 2'h0;
			filter_source_select      <= 1'b0;
			attenuation_level         <= 3'h0;
			volume_source_select      <= 2'h0;
			config_applied            <= 1'b0;
		end else begin
			config_applied <= pending_apply && power_up_bit;
			if (pending_apply && power_up_bit) begin
				analog_out_source_select <= active_low[`APC_AOUT_SRC_MSB:`APC_AOUT_SRC_LSB];
				pass_through_path <= active_low[`APC_AOUT_SRC_MSB:`APC_AOUT_SRC_LSB]
					== `APC_AOUT_PASS_THRU;
				analog_out_power_down <= active_low[`APC_AOUT_PD_BIT];
				analog_in_gain <= active_low[`APC_AIN_GAIN_MSB:`APC_AIN_GAIN_LSB];
				analog_in_power_down <= active_low[`APC_AIN_PD_BIT];
				output_source_select <= active_low[`APC_OUT_SRC_MSB:`APC_OUT_SRC_LSB];
				speaker_driver_control <= active_low[`APC_SPK_MSB:`APC_SPK_LSB];
				speaker_high_gain <= active_low[`APC_SPK_MSB:`APC_SPK_LSB]
					== `APC_SPK_HIGH_GAIN;
				aux_out_power_down <= active_low[`APC_SPK_MSB:`APC_SPK_LSB]
					== `APC_SPK_HIGH_GAIN;
				volume_power_down <= active_low[`APC_VOL_PD_BIT];
				aux_in_power_down <= active_low[`APC_AUX_PD_BIT];
				aux_in_gain <= active_low[`APC_AUX_GAIN_MSB:`APC_AUX_GAIN_LSB];
				input_source_select <= active_low[`APC_IN_SRC_BIT];
				first_mixer_mode <= active_high[`APC_MIX1_MSB:`APC_MIX1_LSB];
				second_mixer_mode <= active_high[`APC_MIX2_MSB:`APC_MIX2_LSB];
				first_mixer_power_down <= active_high[`APC_MIX1_MSB:`APC_MIX1_LSB]
					== `APC_MIX_OFF;
				second_mixer_power_down <= active_high[`APC_MIX2_MSB:`APC_MIX2_LSB]
					== `APC_MIX_OFF;
				first_mixer_source_select <= active_high[`APC_MIX1_SRC_MSB:`APC_MIX1_SRC_LSB];
				filter_power_down <= active_high[`APC_FILT_PD_BIT];
				gain_control_power_down <= active_high[`APC_AGC_PD_BIT];
				sample_rate_select <= active_high[`APC_RATE_MSB:`APC_RATE_LSB];
				filter_source_select <= active_high[`APC_FILT_SRC_BIT];
				attenuation_level <= active_high[`APC_ATTEN_MSB:`APC_ATTEN_LSB];
				volume_source_select <= active_high[`APC_VOL_SRC_MSB:`APC_VOL_SRC_LSB];
			end
		end
	end

endmodule // apc_config_regs
`default_nettype wire

// ==== apc_config_props.sv ====
// Checker of the configuration block's decoded outputs and update pulse.
// Assumes binding to apc_config_regs; it watches that module's ports only.
`default_nettype none
module apc_config_props (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst_n,
	// Watched ports
	input wire logic       power_up_bit,
	input wire logic [2:0] analog_out_source_select,
	input wire logic       pass_through_path,
	input wire logic [1:0] speaker_driver_control,
	input wire logic       speaker_high_gain,
	input wire logic       aux_out_power_down,
	input wire logic [1:0] first_mixer_mode,
	input wire logic       first_mixer_power_down,
	input wire logic [1:0] second_mixer_mode,
	input wire logic       second_mixer_power_down,
	input wire logic [2:0] attenuation_level,
	input wire logic       config_applied
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Decoded flags must follow their fields in every cycle
	chk_pass_thru: assert property (
		pass_through_path == (analog_out_source_select == 3'h0))
		else $error("pass-through flag disagrees with source field");
	chk_spk_gain: assert property (
		speaker_high_gain == (speaker_driver_control == 2'h1))
		else $error("speaker gain flag disagrees with driver field");
	chk_aux_out_off: assert property (
		aux_out_power_down == (speaker_driver_control == 2'h1))
		else $error("aux output flag disagrees with driver field");
	chk_mix1_off: assert property (
		first_mixer_power_down == (first_mixer_mode == 2'h3))
		else $error("first mixer power flag wrong");
	chk_mix2_off: assert property (
		second_mixer_power_down == (second_mixer_mode == 2'h3))
		else $error("second mixer power flag wrong");
	// Settings move only together with the update pulse
	chk_change_applied: assert property (
		!config_applied |-> $stable(attenuation_level) && $stable(analog_out_source_select))
		else $error("settings changed without update pulse");
	chk_gate_held: assert property (!power_up_bit |=> !config_applied)
		else $error("update while powered down");
	chk_pulse_single: assert property (config_applied |=> !config_applied)
		else $error("update pulse longer than one cycle");
endmodule // apc_config_props

bind apc_config_regs apc_config_props u_props (.sys_clk, .rst_n, .power_up_bit,
	.analog_out_source_select, .pass_through_path, .speaker_driver_control, .speaker_high_gain,
	.aux_out_power_down, .first_mixer_mode, .first_mixer_power_down, .second_mixer_mode,
	.second_mixer_power_down, .attenuation_level, .config_applied);
`default_nettype wire

// ==== apc_host_model.sv ====
// Host model: serial master sending one opcode byte and one data word.
// Assumes sys_clk paces it; every level holds five cycles for the pin filter.
`default_nettype none
module apc_host_model (
	// Pacing clock
	input wire logic sys_clk,
	// Serial master pins
	output var logic ss_n,
	output var logic sclk,
	output var logic mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle: deselected, clock parked low
	initial begin
		ss_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b1;
	end
	// Five cycles, since the slave drops anything under two
	task automatic hold();
		repeat (5) @(posedge sys_clk);
		#1;
	endtask
	task automatic send(input logic [7:0] op, input logic [15:0] data);
		logic [23:0] frame;
		frame = {op, data};
		hold();
		ss_n = 1'b0;
		for (int b = 23; b >= 0; b--) begin
			mosi = frame[b];
			hold();
			sclk = 1'b1;
			hold();
			sclk = 1'b0;
		end
		hold();
		ss_n = 1'b1;
		// Released line flips so no stale bit survives
		mosi = ~mosi;
		hold();
	endtask
endmodule // apc_host_model
`default_nettype wire

// ==== test_audio_path_config_registers.sv ====
// Testbench: loads both registers through the host model and checks fields.
// Assumes apc_config_regs, apc_host_model and the bound checker are compiled.
`default_nettype none
`include "apc_consts.vh"
module test_audio_path_config_registers;
	timeunit 1ns;
	timeprecision 1ps;
	logic       sys_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       power_up_bit = 1'b0;
	logic       ss_n, sclk, mosi, config_applied;
	logic [2:0] analog_out_source_select, attenuation_level;
	logic [1:0] analog_in_gain, output_source_select, speaker_driver_control, aux_in_gain;
	logic [1:0] first_mixer_mode, second_mixer_mode, first_mixer_source_select;
	logic [1:0] sample_rate_select, volume_source_select;
	logic       analog_out_power_down, pass_through_path, analog_in_power_down;
	logic       speaker_high_gain, aux_out_power_down, volume_power_down, aux_in_power_down;
	logic       input_source_select, first_mixer_power_down, second_mixer_power_down;
	logic       filter_power_down, gain_control_power_down, filter_source_select;
	int         err_total = 0;
	int         n_checks = 0;
	// Visible fields packed back into register words
	wire logic [15:0] low_seen = {analog_in_gain, analog_in_power_down, aux_in_gain,
		aux_in_power_down, input_source_select, analog_out_source_select,
		analog_out_power_down, output_source_select, speaker_driver_control, volume_power_down};
	wire logic [15:0] high_seen = {volume_source_select, attenuation_level,
		first_mixer_source_select, first_mixer_mode, second_mixer_mode, filter_source_select,
		sample_rate_select, filter_power_down, gain_control_power_down};

	// 50 MHz clock
	always #10 sys_clk = ~sys_clk;

	apc_host_model host (.sys_clk, .ss_n, .sclk, .mosi);
	apc_config_regs DUT (.sys_clk, .rst_n, .ss_n, .sclk, .mosi, .power_up_bit,
		.analog_out_source_select, .analog_out_power_down, .pass_through_path, .analog_in_gain,
		.analog_in_power_down, .output_source_select, .speaker_driver_control,
		.speaker_high_gain, .aux_out_power_down, .volume_power_down, .aux_in_power_down,
		.aux_in_gain, .input_source_select, .first_mixer_mode, .first_mixer_power_down,
		.second_mixer_mode, .second_mixer_power_down, .first_mixer_source_select,
		.filter_power_down, .gain_control_power_down, .sample_rate_select,
		.filter_source_select, .attenuation_level, .volume_source_select, .config_applied);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	// Bounded watch for the one-cycle update pulse
	task automatic settle(input logic exp_apply);
		logic seen;
		seen = 1'b0;
		repeat (40) begin
			@(posedge sys_clk);
			#1;
			if (config_applied === 1'b1) begin
				seen = 1'b1;
			end
		end
		check({15'h0, seen}, {15'h0, exp_apply}, "update pulse");
	endtask
	task automatic load(input logic [7:0] op, input logic [15:0] data, input logic exp_apply);
		host.send(op, data);
		settle(exp_apply);
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Main sequence; the record step and code sweep load the high word with no low load first
	initial begin
		logic [2:0]  k;
		logic [15:0] hi;
		repeat (5) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		settle(1'b0);
		check(low_seen, `APC_LOW_RESET, "reset low");
		check(high_seen, `APC_HIGH_RESET, "reset high");
		power_up_bit = 1'b1;
		settle(1'b1);
		$display("test reset done");
		load(`APC_OP_LOAD_LOW, 16'h440B, 1'b0);
		load(`APC_OP_LOAD_HIGH, 16'h01E3, 1'b1);
		check(low_seen, 16'h440B, "feed low");
		check(high_seen, 16'h01E3, "feed high");
		check({13'h0, pass_through_path, speaker_high_gain, aux_out_power_down},
			16'h7, "flags");
		check({14'h0, first_mixer_power_down, second_mixer_power_down}, 16'h3, "mix off");
		$display("test feed-through done");
		load(`APC_OP_LOAD_HIGH, 16'h00C5, 1'b1);
		check(low_seen, 16'h440B, "record low");
		check(high_seen, 16'h00C5, "record high");
		load(`APC_OP_LOAD_LOW, 16'h2421, 1'b0);
		check(low_seen, 16'h440B, "buffered low");
		load(`APC_OP_LOAD_HIGH, 16'h0148, 1'b1);
		check(low_seen, 16'h2421, "memo low");
		check(high_seen, 16'h0148, "memo high");
		$display("test buffering done");
		power_up_bit = 1'b0;
		load(`APC_OP_LOAD_LOW, 16'h2422, 1'b0);
		load(`APC_OP_LOAD_HIGH, 16'h59D1, 1'b0);
		check(low_seen, 16'h2421, "frozen low");
		power_up_bit = 1'b1;
		settle(1'b1);
		check(low_seen, 16'h2422, "woken low");
		check(high_seen, 16'h59D1, "woken high");
		load(8'hBA, 16'hFFFF, 1'b0);
		check(high_seen, 16'h59D1, "foreign opcode");
		$display("test power gate done");
		for (int i = 0; i < 8; i++) begin
			k = i[2:0];
			hi = {k[1:0], k, k[1:0], 2'h3, 2'h3, k[0], k[1:0], 2'h3};
			load(`APC_OP_LOAD_HIGH, hi, 1'b1);
			check(high_seen, hi, "code sweep");
		end
		$display("test code sweep done");
		give_verdict();
	end

	// Watchdog well beyond the expected 4845 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		$display("wrong value at %0t: watchdog ran out", $time);
		give_verdict();
	end
endmodule // test_audio_path_config_registers
`default_nettype wire
